// file: core/pmr_regs.sv
/*
 * Power-management control/status, bridge support extension and data registers.
 * Assumes a dword configuration access port on the core clock, and revision select
 * and clock stop bits driven by the general control register on the same clock.
 */
// How it works
// - wake event flag, top control/status bit, reads zero; writes ignored
// - power figure multiplier field is read-only zero
// - power figure selector field is read-only zero
// - wake enable is a plain storage bit, reset zero, no side effects
// - spare bits 7:4 and 2 of control/status read zero
// - revision select clear makes the context-retention flag read zero
// - revision select set: flag reads one; no reset on D3hot to D0
// - power level field is writable, reports and sets the present state
// - clock stop flag mirrors the general control clock stop bit
// - flag set: secondary clocks stop in D3hot; clear: keep running
// - secondary bus level flag always reads one
// - low six bits of bridge extension byte read zero
// - bridge extension byte at 56h is read-only, resets to 40h
// - data byte at 57h is read-only zero
// - control/status sits at 54h, 16 bits, default 0008h
`include "pmr_defines.svh"

module pmr_regs (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic pm_revision_select_i,
  input wire logic secondary_clock_stop_cfg_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  output logic cfg_hit_o,
  output pmr_pkg::pmr_power_t power_level_o,
  output logic in_d3hot_o,
  output logic sec_clk_run_o,
  output logic d3_exit_o
);
  import pmr_pkg::*;

  localparam pmr_top_state_t RST = '{
    rdata: `PMR_WORD_ZERO,
    rvalid: 1'b0,
    hit: 1'b0,
    prev_level: PMR_D0,
    sec_clk_run: 1'b1,
    in_d3hot: 1'b0,
    d3_exit: 1'b0
  };

  pmr_top_state_t s_q;
  pmr_top_state_t s_d;
  logic dword_hit;
  logic csr_wr;
  pmr_power_t level;
  logic wake_en;
  logic [31:0] rd_word;

  // only the dword holding 54h..57h belongs to this group
  assign dword_hit = (cfg_addr_i & `PMR_DWORD_MASK) == `PMR_CSR_OFFSET;
  // bytes 56h and 57h have no storage, so only lanes 0 and 1 can write
  assign csr_wr = cfg_wr_i && dword_hit;

  pmr_state_reg u_state (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(csr_wr),
    .be_i(cfg_be_i[1:0]),
    .wdata_i(cfg_wdata_i[15:0]),
    .power_level_o(level),
    .wake_enable_o(wake_en)
  );

  pmr_rd_word u_rd (
    .power_level_i(level),
    .wake_enable_i(wake_en),
    .pm_revision_select_i(pm_revision_select_i),
    .secondary_clock_stop_cfg_i(secondary_clock_stop_cfg_i),
    .word_o(rd_word)
  );

  always_comb begin
    s_d = s_q;
    s_d.rvalid = cfg_rd_i;
    s_d.hit = cfg_rd_i && dword_hit;
    if (cfg_rd_i) begin
      // unmapped reads answer zero with hit low
      s_d.rdata = dword_hit ? rd_word : `PMR_WORD_ZERO;
    end
    s_d.prev_level = level;
    s_d.in_d3hot = level == PMR_D3HOT;
    // clocks stop only in D3hot and only when the stop bit asks for it
    s_d.sec_clk_run = !(secondary_clock_stop_cfg_i && level == PMR_D3HOT);
    // leaving D3hot for D0 is reported only; context is kept and no reset is raised
    s_d.d3_exit = s_q.prev_level == PMR_D3HOT && level == PMR_D0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata_o = s_q.rdata;
  assign cfg_rvalid_o = s_q.rvalid;
  assign cfg_hit_o = s_q.hit;
  assign power_level_o = level;
  assign in_d3hot_o = s_q.in_d3hot;
  assign sec_clk_run_o = s_q.sec_clk_run;
  assign d3_exit_o = s_q.d3_exit;

endmodule : pmr_regs

// file: core/pmr_defines.svh
/*
 * Offsets, field positions and fixed values of the power-management register group.
 * Assumes byte offsets in configuration space with dword-aligned accesses.
 */
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

// byte offsets in configuration space
`define PMR_CSR_OFFSET 8'h54
`define PMR_EXT_OFFSET 8'h56
`define PMR_DATA_OFFSET 8'h57
`define PMR_DWORD_MASK 8'hFC

// control/status field positions
`define PMR_CSR_WAKE_FLAG_BIT 15
`define PMR_CSR_WAKE_EN_BIT 8
`define PMR_CSR_CTX_BIT 3
`define PMR_CSR_PWR_LSB 0

// bridge support extension field positions
`define PMR_EXT_CLK_STOP_BIT 7
`define PMR_EXT_BUS_LVL_BIT 6

// reset and fixed values
`define PMR_CSR_RESET 16'h0008
`define PMR_EXT_RESET 8'h40
`define PMR_DATA_RESET 8'h00
`define PMR_WORD_ZERO 32'h0000_0000

`endif

// file: core/pmr_pkg.sv
/*
 * Types shared by the power-management register group.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmr_pkg;

  // encoded as the power level field reads
  typedef enum logic [1:0] {
    PMR_D0,
    PMR_D1,
    PMR_D2,
    PMR_D3HOT
  } pmr_power_t;

  typedef struct packed {
    pmr_power_t level;
    logic wake_en;
  } pmr_csr_state_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
    logic hit;
    pmr_power_t prev_level;
    logic sec_clk_run;
    logic in_d3hot;
    logic d3_exit;
  } pmr_top_state_t;

endpackage : pmr_pkg

// file: core/pmr_state_reg.sv
/*
 * Writable fields of the control/status register: power level and wake-enable scratch bit.
 * Assumes the caller has decoded the write to the register's dword.
 */
`include "pmr_defines.svh"

module pmr_state_reg (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic [1:0] be_i,
  input wire logic [15:0] wdata_i,
  output pmr_pkg::pmr_power_t power_level_o,
  output logic wake_enable_o
);
  import pmr_pkg::*;

  localparam pmr_csr_state_t RST = '{level: PMR_D0, wake_en: 1'b0};

  pmr_csr_state_t s_q;
  pmr_csr_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr_i && be_i[0]) begin
      s_d.level = pmr_power_t'(wdata_i[`PMR_CSR_PWR_LSB +: 2]);
    end
    if (wr_i && be_i[1]) begin
      s_d.wake_en = wdata_i[`PMR_CSR_WAKE_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign power_level_o = s_q.level;
  assign wake_enable_o = s_q.wake_en;

endmodule : pmr_state_reg

// file: core/pmr_rd_word.sv
/*
 * Assembles the read dword at 54h: control/status, bridge extension and data bytes.
 * Assumes the general control bits come from logic on the same clock.
 */
`include "pmr_defines.svh"

module pmr_rd_word (
  input pmr_pkg::pmr_power_t power_level_i,
  input wire logic wake_enable_i,
  input wire logic pm_revision_select_i,
  input wire logic secondary_clock_stop_cfg_i,
  output logic [31:0] word_o
);
  import pmr_pkg::*;

  logic [15:0] csr;
  logic [7:0] ext;

  always_comb begin
    // wake flag, figure multiplier/selector and spare bits stay zero
    csr = 16'h0000;
    csr[`PMR_CSR_PWR_LSB +: 2] = power_level_i;
    csr[`PMR_CSR_WAKE_EN_BIT] = wake_enable_i;
    csr[`PMR_CSR_CTX_BIT] = pm_revision_select_i;
    ext = `PMR_EXT_RESET;
    ext[`PMR_EXT_CLK_STOP_BIT] = secondary_clock_stop_cfg_i;
    word_o = {`PMR_DATA_RESET, ext, csr};
  end

endmodule : pmr_rd_word

// file: tb/pmr_regs_checker.sv
/* port assertions for the power-management register group
   bound to pmr_regs; one core clock, async active-high reset */
module pmr_regs_checker import pmr_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic pm_revision_select_i,
  input wire logic secondary_clock_stop_cfg_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic cfg_hit_o,
  input wire pmr_power_t power_level_o,
  input wire logic in_d3hot_o,
  input wire logic sec_clk_run_o,
  input wire logic d3_exit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic rh;
  wire logic wl;
  assign rh = cfg_rvalid_o && cfg_hit_o;
  assign wl = cfg_wr_i && cfg_be_i[0] && cfg_addr_i[7:2] == 6'h15;
  property p_rv; cfg_rd_i |=> cfg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  property p_miss; cfg_rd_i && cfg_addr_i[7:2] != 6'h15 |=> !cfg_hit_o; endproperty
  a_miss: assert property (p_miss) else $error("hit on other address");
  property p_fix; rh |-> cfg_rdata_o[31:16] == 16'h0040 || cfg_rdata_o[31:16] == 16'h00c0;
  endproperty
  a_fix: assert property (p_fix) else $error("upper bytes wrong");
  property p_zero; rh |-> cfg_rdata_o[15:9] == 7'h00 && cfg_rdata_o[7:4] == 4'h0 &&
    !cfg_rdata_o[2]; endproperty
  a_zero: assert property (p_zero) else $error("fixed zero bits set");
  property p_ctx; rh |-> cfg_rdata_o[3] == $past(pm_revision_select_i); endproperty
  a_ctx: assert property (p_ctx) else $error("context flag wrong");
  property p_stop; rh |-> cfg_rdata_o[23] == $past(secondary_clock_stop_cfg_i); endproperty
  a_stop: assert property (p_stop) else $error("clock stop flag wrong");
  property p_lvl; rh |-> cfg_rdata_o[1:0] == $past(power_level_o); endproperty
  a_lvl: assert property (p_lvl) else $error("level readback wrong");
  property p_wr; wl |=> power_level_o == $past(cfg_wdata_i[1:0]); endproperty
  a_wr: assert property (p_wr) else $error("level not written");
  property p_keep; !wl |=> $stable(power_level_o); endproperty
  a_keep: assert property (p_keep) else $error("level changed");
  property p_run; sec_clk_run_o == !($past(power_level_o) == PMR_D3HOT &&
    $past(secondary_clock_stop_cfg_i)); endproperty
  a_run: assert property (p_run) else $error("clock run wrong");
endmodule : pmr_regs_checker

bind pmr_regs pmr_regs_checker u_chk (.*);

// file: tb/tb_top.sv
/* random config traffic against an integer and queue model
   assumes pmr_regs and pmr_pkg compiled first */
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, sys_rst_i = 1, wr = 0, rd = 0, rev = 1, cs = 0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdat, r = 32'h984a, er = 0;
  logic rv, hit, d3, run, dx, ev = 0, eh = 0, pc = 0;
  logic [31:0] eq[$];
  pmr_pkg::pmr_power_t lv;
  int fails = 0, comparisons = 0, cyc = 0, ml = 0, pl = 0, pp = 0, wen = 0;
  always #50 clk_i = ~clk_i;
  pmr_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_addr_i(addr), .cfg_wr_i(wr),
    .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wd), .pm_revision_select_i(rev),
    .secondary_clock_stop_cfg_i(cs), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv), .cfg_hit_o(hit),
    .power_level_o(lv), .in_d3hot_o(d3), .sec_clk_run_o(run), .d3_exit_o(dx));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 0;
    for (int k = 0; k < 600; k++) begin
      @(posedge clk_i);
      r = xs(r);
      rd <= k == 0 || r[16];
      wr <= k != 0 && r[17];
      addr <= (k == 0 || r[0]) ? {6'h15, r[2:1]} : r[15:8];
      be <= r[23:20];
      // level bits drawn apart from the byte enables so every level gets written
      wd <= xs(r);
      rev <= k == 0 || r[18];
      cs <= k != 0 && r[19];
      @(negedge clk_i);
      if (eq.size() > 0) er = eq.pop_front();
      `CHK("rvalid", ev, rv)
      `CHK("hit", eh, hit)
      `CHK("rdata", er, rdat)
      `CHK("level", ml[1:0], lv)
      `CHK("d3hot", pl == 3, d3)
      `CHK("clkrun", !(pc && pl == 3), run)
      `CHK("d3exit", pp == 3 && pl == 0, dx)
      pp = pl;
      pl = ml;
      pc = cs;
      ev = rd;
      eh = rd && addr[7:2] == 6'h15;
      if (rd) eq.push_back(eh ? {8'h00, cs, 7'h40, 7'h00, wen[0], 4'h0, rev, 1'b0, ml[1:0]} :
        32'h0000_0000);
      if (wr && addr[7:2] == 6'h15 && be[0]) ml = wd[1:0];
      if (wr && addr[7:2] == 6'h15 && be[1]) wen = wd[8];
    end
    report_and_stop;
  end
endmodule : tb_top
